// ### src/ram_pointer_and_config_regs.sv
// buffer pointer, indirect selector and configuration register group
// Behaviour
// [R01] upper pointer bit 7 gives next buffer access direction, 1 read, 0 write
// [R02] upper pointer bit 6 set advances pointer after each data access
// [R03] upper pointer bits 2-0 give buffer address bits 10-8
// [R04] lower pointer register gives buffer address bits 7-0
// [R05] upper bits 5-3 and selector bits 7-3 unused, read zero here
// [R06] three-bit selector chooses register behind indirect location 07
// [R07] low two selector bits are shared storage with configuration bits 1-0
// [R08] any configuration write clears selector top bit
// [R09] configuration bit 7 set holds device in software reset
// [R10] software reset keeps interface mode and configuration contents
// [R11] software reset only reinitialises status, next ID, diagnostic status
// [R12] host writes configuration bit 7 back to 0 to end software reset
// [R13] data access uses current pointer; step applied after access
// [R14] configuration bit 6 set enables command chaining
`timescale 1ns/1ps
module ram_pointer_and_config_regs
  import ram_ptr_cfg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // buffer data-port access from the core
  input wire logic data_access,
  // buffer addressing and controls to the core
  output logic [10:0] ram_addr,
  output logic read_direction,
  output logic [2:0] indirect_select,
  output logic soft_reset,
  output logic chained_command_enable
);

  // ****************************************
  // register state
  // ****************************************
  logic read_dir_bit;
  logic pointer_step_enable;
  logic [2:0] ram_addr_upper;
  logic [7:0] ram_addr_lower;
  logic indirect_select_top;
  logic indirect_select_mid;
  logic indirect_select_low;
  logic soft_reset_bit;
  logic chain_bit;
  logic [3:0] cfg_middle;
  logic [7:0] rdata_hold;

  logic next_read_dir;
  logic next_step_enable;
  logic [10:0] next_pointer;
  logic next_sel_top;
  logic next_sel_mid;
  logic next_sel_low;
  logic next_soft_reset;
  logic next_chain;
  logic [3:0] next_cfg_middle;
  logic [7:0] next_rdata;

  logic wr_upper;
  logic wr_lower;
  logic wr_sel;
  logic wr_cfg;

  assign wr_upper = reg_write && (reg_addr == OFS_POINTER_UPPER);
  assign wr_lower = reg_write && (reg_addr == OFS_POINTER_LOWER);
  assign wr_sel = reg_write && (reg_addr == OFS_SELECTOR);
  assign wr_cfg = reg_write && (reg_addr == OFS_CONFIG);

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    next_read_dir = read_dir_bit;
    next_step_enable = pointer_step_enable;
    next_pointer = {ram_addr_upper, ram_addr_lower};
    next_sel_top = indirect_select_top;
    next_sel_mid = indirect_select_mid;
    next_sel_low = indirect_select_low;
    next_soft_reset = soft_reset_bit;
    next_chain = chain_bit;
    next_cfg_middle = cfg_middle;
    // [R13] step after access completes
    if (data_access && pointer_step_enable) begin
      // [R02] automatic pointer advance
      next_pointer = {ram_addr_upper, ram_addr_lower} + POINTER_STEP;
    end
    // a host pointer write wins over a step in the same cycle for the half it writes
    if (wr_upper) begin
      // [R01] direction bit stored
      next_read_dir = reg_wdata[BIT_READ_DIRECTION];
      next_step_enable = reg_wdata[BIT_POINTER_STEP];
      // [R03] upper address bits
      next_pointer[10:8] = reg_wdata[2:0];
    end
    if (wr_lower) begin
      // [R04] lower address bits
      next_pointer[7:0] = reg_wdata;
    end
    if (wr_sel) begin
      // [R06] three-bit selector
      next_sel_top = reg_wdata[BIT_SELECT_TOP];
      next_sel_mid = reg_wdata[1];
      next_sel_low = reg_wdata[0];
    end
    if (wr_cfg) begin
      // [R08] config write drops top selector bit
      next_sel_top = 1'b0;
      // [R07] shared low selector bits
      next_sel_mid = reg_wdata[1];
      next_sel_low = reg_wdata[0];
      // [R09] soft reset follows the bit; [R12] cleared only by host write or hardware reset
      next_soft_reset = reg_wdata[BIT_SOFT_RESET];
      // [R14] chaining enable
      next_chain = reg_wdata[BIT_CHAIN_ENABLE];
      next_cfg_middle = reg_wdata[BIT_CFG_MIDDLE_HI:BIT_CFG_MIDDLE_LO];
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    next_rdata = 8'h00;
    if (reg_read) begin
      unique case (reg_addr)
        // [R05] unused bits read zero
        OFS_POINTER_UPPER: next_rdata = {read_dir_bit, pointer_step_enable, 3'h0, ram_addr_upper};
        OFS_POINTER_LOWER: next_rdata = ram_addr_lower;
        OFS_SELECTOR: next_rdata = {5'h00, indirect_select_top, indirect_select_mid,
                                    indirect_select_low};
        OFS_CONFIG: next_rdata = {soft_reset_bit, chain_bit, cfg_middle,
                                  indirect_select_mid, indirect_select_low};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // [R10] hardware reset clears these; soft reset touches none of them
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      read_dir_bit <= RESET_POINTER_UPPER[BIT_READ_DIRECTION];
      pointer_step_enable <= RESET_POINTER_UPPER[BIT_POINTER_STEP];
      ram_addr_upper <= RESET_POINTER_UPPER[2:0];
      ram_addr_lower <= RESET_POINTER_LOWER;
      indirect_select_top <= RESET_SELECTOR[2];
      indirect_select_mid <= RESET_SELECTOR[1];
      indirect_select_low <= RESET_SELECTOR[0];
      soft_reset_bit <= 1'b0;
      chain_bit <= 1'b0;
      cfg_middle <= RESET_CFG_MIDDLE;
      rdata_hold <= 8'h00;
    end else begin
      read_dir_bit <= next_read_dir;
      pointer_step_enable <= next_step_enable;
      ram_addr_upper <= next_pointer[10:8];
      ram_addr_lower <= next_pointer[7:0];
      indirect_select_top <= next_sel_top;
      indirect_select_mid <= next_sel_mid;
      indirect_select_low <= next_sel_low;
      soft_reset_bit <= next_soft_reset;
      chain_bit <= next_chain;
      cfg_middle <= next_cfg_middle;
      rdata_hold <= next_rdata;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // [R11] soft reset is handed to status, next ID and diagnostic logic only
  assign soft_reset = soft_reset_bit;
  assign chained_command_enable = chain_bit;
  assign read_direction = read_dir_bit;
  assign ram_addr = {ram_addr_upper, ram_addr_lower};
  assign indirect_select = {indirect_select_top, indirect_select_mid, indirect_select_low};
  assign reg_rdata = rdata_hold;

  // ****************************************
  // assertions
  // ****************************************
  AST_STEP_ADVANCES: assert property (@(posedge clk) disable iff (reset) // [R02]
    (data_access && pointer_step_enable && !wr_upper && !wr_lower)
      |=> (ram_addr == $past(ram_addr) + POINTER_STEP))
    else $error("pointer did not advance after access");
  AST_NO_STEP_HOLDS: assert property (@(posedge clk) disable iff (reset) // [R13]
    (!pointer_step_enable && !wr_upper && !wr_lower) |=> $stable(ram_addr))
    else $error("pointer moved without step enable");
  AST_DIR_WRITE: assert property (@(posedge clk) disable iff (reset) // [R01]
    wr_upper |=> (read_direction == $past(reg_wdata[BIT_READ_DIRECTION])))
    else $error("direction bit not stored");
  AST_UPPER_ADDR: assert property (@(posedge clk) disable iff (reset) // [R03]
    wr_upper |=> (ram_addr[10:8] == $past(reg_wdata[2:0])))
    else $error("upper address not stored");
  AST_LOWER_ADDR: assert property (@(posedge clk) disable iff (reset) // [R04]
    wr_lower |=> (ram_addr[7:0] == $past(reg_wdata)))
    else $error("lower address not stored");
  AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (reset) // [R05]
    (reg_read && reg_addr == OFS_SELECTOR) |=> (reg_rdata[7:3] == 5'h00))
    else $error("selector unused bits not zero");
  AST_SEL_WRITE: assert property (@(posedge clk) disable iff (reset) // [R06]
    (wr_sel && !wr_cfg) |=> (indirect_select == $past(reg_wdata[2:0])))
    else $error("selector not stored");
  AST_SHARED_BITS: assert property (@(posedge clk) disable iff (reset) // [R07]
    (reg_read && reg_addr == OFS_CONFIG) |=> (reg_rdata[1:0] == indirect_select[1:0]))
    else $error("shared selector bits differ");
  AST_CFG_CLEARS_TOP: assert property (@(posedge clk) disable iff (reset) // [R08]
    wr_cfg |=> !indirect_select[2])
    else $error("top selector bit not cleared");
  AST_SOFT_RESET_HOLDS: assert property (@(posedge clk) disable iff (reset) // [R09]
    (soft_reset && !wr_cfg) |=> soft_reset)
    else $error("soft reset released without host write");
  AST_CHAIN_BIT: assert property (@(posedge clk) disable iff (reset) // [R14]
    wr_cfg |=> (chained_command_enable == $past(reg_wdata[BIT_CHAIN_ENABLE])))
    else $error("chaining enable not stored");
  AST_SOFT_KEEPS_PTR: assert property (@(posedge clk) disable iff (reset) // [R10]
    (soft_reset && !wr_upper && !wr_lower && !data_access) |=> $stable(ram_addr))
    else $error("soft reset disturbed pointer");

  // ****************************************
  // read path assertions
  // ****************************************
  // read answer lasts one cycle; idle cycles show zero so stale bytes never linger
  AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (reset) // [R05]
    !reg_read |=> (reg_rdata == 8'h00))
    else $error("read data not zero outside answer cycle");

  AST_UPPER_RESERVED: assert property (@(posedge clk) disable iff (reset) // [R05]
    (reg_read && reg_addr == OFS_POINTER_UPPER) |=> (reg_rdata[5:3] == 3'h0))
    else $error("upper pointer unused bits not zero");

  AST_UPPER_READ: assert property (@(posedge clk) disable iff (reset) // [R01]
    (reg_read && reg_addr == OFS_POINTER_UPPER)
      |=> (reg_rdata[BIT_READ_DIRECTION] == $past(read_direction)
           && reg_rdata[2:0] == $past(ram_addr[10:8])))
    else $error("upper pointer read back wrong");

  AST_LOWER_READ: assert property (@(posedge clk) disable iff (reset) // [R04]
    (reg_read && reg_addr == OFS_POINTER_LOWER) |=> (reg_rdata == $past(ram_addr[7:0])))
    else $error("lower pointer read back wrong");

  AST_SEL_READ: assert property (@(posedge clk) disable iff (reset) // [R06]
    (reg_read && reg_addr == OFS_SELECTOR) |=> (reg_rdata[2:0] == $past(indirect_select)))
    else $error("selector read back wrong");

  AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (reset) // [R05]
    (reg_read && reg_addr != OFS_POINTER_UPPER && reg_addr != OFS_POINTER_LOWER
      && reg_addr != OFS_SELECTOR && reg_addr != OFS_CONFIG) |=> (reg_rdata == 8'h00))
    else $error("unmapped read not zero");

  // ****************************************
  // pointer stepping assertions
  // ****************************************
  // the written half wins a collision; the other half still takes the stepped value
  // wrap from the top of the buffer lands at address zero
  AST_STEP_CARRY: assert property (@(posedge clk) disable iff (reset) // [R13]
    (data_access && pointer_step_enable && !wr_upper && !wr_lower && ram_addr[7:0] == 8'hFF)
      |=> (ram_addr[10:8] == $past(ram_addr[10:8]) + 3'h1))
    else $error("step did not carry into upper address");

  AST_LOWER_WRITE_WINS: assert property (@(posedge clk) disable iff (reset) // [R04]
    (data_access && pointer_step_enable && wr_lower) |=> (ram_addr[7:0] == $past(reg_wdata)))
    else $error("lower write lost against step");

  AST_LOWER_STEPS_BESIDE_UPPER: assert property (@(posedge clk) disable iff (reset) // [R13]
    (data_access && pointer_step_enable && wr_upper) |=> (ram_addr[7:0] == $past(ram_addr[7:0]) + 8'h01))
    else $error("lower half missed step beside upper write");

  AST_STEP_STORED: assert property (@(posedge clk) disable iff (reset) // [R02]
    wr_upper |=> (pointer_step_enable == $past(reg_wdata[BIT_POINTER_STEP])))
    else $error("step enable not stored");

  AST_DIR_HOLDS: assert property (@(posedge clk) disable iff (reset) // [R01]
    !wr_upper |=> $stable(read_direction))
    else $error("direction changed without upper write");

  // ****************************************
  // selector and configuration assertions
  // ****************************************
  // selector top bit is only reachable through the selector register
  AST_SEL_HOLDS: assert property (@(posedge clk) disable iff (reset) // [R06]
    (!wr_sel && !wr_cfg) |=> $stable(indirect_select))
    else $error("selector changed without a write");

  AST_CFG_LOW_WRITE: assert property (@(posedge clk) disable iff (reset) // [R07]
    wr_cfg |=> (indirect_select[1:0] == $past(reg_wdata[1:0])))
    else $error("config write missed shared selector bits");

  AST_SOFT_RESET_SET: assert property (@(posedge clk) disable iff (reset) // [R09]
    wr_cfg |=> (soft_reset == $past(reg_wdata[BIT_SOFT_RESET])))
    else $error("soft reset bit not stored");

  AST_SOFT_KEEPS_CFG: assert property (@(posedge clk) disable iff (reset) // [R10]
    (soft_reset && !wr_cfg) |=> ($stable(cfg_middle) && $stable(chained_command_enable)))
    else $error("soft reset disturbed configuration");

  AST_CHAIN_HOLDS: assert property (@(posedge clk) disable iff (reset) // [R14]
    !wr_cfg |=> $stable(chained_command_enable))
    else $error("chaining enable changed without config write");
endmodule

// ### src/ram_ptr_cfg_pkg.sv
// constants for the buffer pointer and configuration register group
package ram_ptr_cfg_pkg;
  // register offsets on the plain register port (byte addresses)
  localparam logic [2:0] OFS_POINTER_UPPER = 3'h2;
  localparam logic [2:0] OFS_POINTER_LOWER = 3'h3;
  localparam logic [2:0] OFS_SELECTOR = 3'h5;
  localparam logic [2:0] OFS_CONFIG = 3'h6;
  // upper pointer fields
  localparam int BIT_READ_DIRECTION = 7;
  localparam int BIT_POINTER_STEP = 6;
  // configuration fields
  localparam int BIT_SOFT_RESET = 7;
  localparam int BIT_CHAIN_ENABLE = 6;
  localparam int BIT_CFG_MIDDLE_HI = 5;
  localparam int BIT_CFG_MIDDLE_LO = 2;
  // selector fields
  localparam int BIT_SELECT_TOP = 2;
  // indirect selector codes
  localparam logic [2:0] SEL_TENTATIVE_ID = 3'h0;
  localparam logic [2:0] SEL_NODE_ID = 3'h1;
  localparam logic [2:0] SEL_SETUP_ONE = 3'h2;
  localparam logic [2:0] SEL_NEXT_ID = 3'h3;
  localparam logic [2:0] SEL_SETUP_TWO = 3'h4;
  // reset values
  localparam logic [7:0] RESET_POINTER_UPPER = 8'h00;
  localparam logic [7:0] RESET_POINTER_LOWER = 8'h00;
  localparam logic [2:0] RESET_SELECTOR = 3'h0;
  localparam logic [3:0] RESET_CFG_MIDDLE = 4'h0;
  localparam logic [10:0] POINTER_STEP = 11'h001;
endpackage

// ### test/host_bus_model.sv
// host bus master model driving the plain register port
`timescale 1ns/1ps
module host_bus_model (
  // clock
  input wire logic clk,
  // register port
  output logic [2:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  // host writes; config bit 7 written low ends soft reset
  // released lines show inverted values so stale data never looks valid
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_wdata <= ~d;
    @(posedge clk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
    @(posedge clk);
  endtask
endmodule

// ### test/tb_top.sv
// self-checking bench for the pointer and configuration register group
`timescale 1ns/1ps
module tb_top
  import ram_ptr_cfg_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic data_access = 1'b0;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_write;
  logic reg_read;
  logic read_direction;
  logic soft_reset;
  logic chained_command_enable;
  logic [10:0] ram_addr;
  logic [2:0] indirect_select;
  // reference state
  logic [10:0] ptr = 11'h000;
  logic [2:0] sel = 3'h0;
  logic [7:0] cfg = 8'h00;
  logic dir = 1'b0;
  logic step = 1'b0;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int seed = 83581;
  int r;
  always #12.5 clk = ~clk;
  host_bus_model i_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
  ram_pointer_and_config_regs i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .data_access(data_access), .ram_addr(ram_addr),
    .read_direction(read_direction), .indirect_select(indirect_select),
    .soft_reset(soft_reset), .chained_command_enable(chained_command_enable));
  // ****************
  // checking helpers
  // ****************
  function automatic logic [7:0] exp_read(input logic [2:0] a);
    case (a)
      OFS_POINTER_UPPER: return {dir, step, 3'h0, ptr[10:8]};
      OFS_POINTER_LOWER: return ptr[7:0];
      OFS_SELECTOR: return {5'h00, sel};
      OFS_CONFIG: return {cfg[7:2], sel[1:0]};
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(input logic [10:0] g, input logic [10:0] e, input string m);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask
  task automatic chk_outs();
    chk(ram_addr, ptr, "pointer");
    chk(11'(read_direction), 11'(dir), "direction");
    chk(11'(indirect_select), 11'(sel), "selector");
    chk(11'(soft_reset), 11'(cfg[7]), "soft reset");
    chk(11'(chained_command_enable), 11'(cfg[6]), "chaining");
  endtask
  function automatic void model_wr(input logic [2:0] a, input logic [7:0] d);
    case (a)
      OFS_POINTER_UPPER: {dir, step, ptr[10:8]} = {d[7:6], d[2:0]};
      OFS_POINTER_LOWER: ptr[7:0] = d;
      OFS_SELECTOR: sel = d[2:0];
      OFS_CONFIG: begin
        cfg = d;
        sel = {1'b0, d[1:0]};
      end
      default: ;
    endcase
  endfunction
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    i_host.wr(a, d);
    model_wr(a, d);
    chk_outs();
  endtask
  // host write landing in the same cycle as a buffer access
  task automatic wr_access(input logic [2:0] a, input logic [7:0] d);
    data_access <= 1'b1;
    fork
      i_host.wr(a, d);
      begin
        @(posedge clk);
        data_access <= 1'b0;
      end
    join
    if (step) ptr = ptr + 11'h001;
    model_wr(a, d);
    chk_outs();
  endtask
  task automatic reg_rd(input logic [2:0] a);
    logic [7:0] got;
    i_host.rd(a, got);
    chk(11'(got), 11'(exp_read(a)), "read data");
  endtask
  task automatic pulse_access();
    data_access <= 1'b1;
    @(posedge clk);
    data_access <= 1'b0;
    @(posedge clk);
    if (step) ptr = ptr + 11'h001;
    chk_outs();
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // hang guard, far above the roughly 860 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      summarize();
    end
  end
  // *********
  // sequences
  // *********
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk_outs();
    reg_wr(OFS_SELECTOR, 8'hFF);
    reg_rd(OFS_SELECTOR);
    reg_rd(OFS_CONFIG);
    reg_wr(OFS_CONFIG, 8'h42);
    reg_rd(OFS_SELECTOR);
    reg_wr(OFS_POINTER_UPPER, 8'hFF);
    reg_rd(OFS_POINTER_UPPER);
    reg_wr(OFS_POINTER_LOWER, 8'hFE);
    repeat (3) pulse_access();
    reg_wr(OFS_POINTER_UPPER, 8'h05);
    pulse_access();
    // host writes colliding with a step
    reg_wr(OFS_POINTER_UPPER, 8'h47);
    reg_wr(OFS_POINTER_LOWER, 8'hFF);
    wr_access(OFS_POINTER_LOWER, 8'h10);
    wr_access(OFS_POINTER_UPPER, 8'h43);
    reg_wr(OFS_CONFIG, 8'h83);
    reg_rd(OFS_CONFIG);
    reg_rd(OFS_POINTER_LOWER);
    reg_wr(OFS_CONFIG, 8'h03);
    reg_rd(3'h7);
    // mid-run hardware reset clears every register
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    ptr = 11'h000;
    sel = 3'h0;
    cfg = 8'h00;
    dir = 1'b0;
    step = 1'b0;
    chk_outs();
    reg_rd(OFS_CONFIG);
    $display("corner tests done");
    for (int i = 0; i < 400; i++) begin
      r = $random(seed);
      case (r[9:8])
        2'd0, 2'd1: reg_wr(r[2:0], r[17:10]);
        2'd2: reg_rd(r[2:0]);
        default: begin
          if (r[20]) begin
            pulse_access();
          end else begin
            wr_access(r[2:0], r[17:10]);
          end
        end
      endcase
    end
    $display("random tests done");
    summarize();
  end
endmodule
